// File: design/fws_pkg.sv
// Purpose: shared constants for the fault and warning signal masking block
// Assumes: 8-bit registers addressed by their byte offsets on a plain port
// Notes:   reserved mask bits are stored but steer nothing

package fws_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_CH = 4;

    // register offsets
    localparam logic [7:0] FAULT_LIVE_OFS   = 8'h1E;
    localparam logic [7:0] WARN_STORED_OFS  = 8'h1F;
    localparam logic [7:0] WARN_LIVE_OFS    = 8'h20;
    localparam logic [7:0] FAULT_PIN_OFS    = 8'h22;
    localparam logic [7:0] SIG_STATUS_OFS   = 8'h2F;

    // reset values
    localparam logic [7:0] FAULT_LIVE_RST   = 8'h00;
    localparam logic [7:0] WARN_STORED_RST  = 8'h04;
    localparam logic [7:0] WARN_LIVE_RST    = 8'h00;
    localparam logic [7:0] FAULT_PIN_RST    = 8'h00;
    localparam logic [7:0] RD_IDLE          = 8'h00;

    // live fault mask fields
    localparam int unsigned FL_FROM_WARN_BIT = 6;
    localparam int unsigned FL_CLK_BIT       = 5;
    localparam int unsigned FL_SHUTDOWN_BIT  = 4;
    localparam int unsigned FL_POWER_BIT     = 3;
    localparam int unsigned FL_DIAG_BIT      = 0;

    // stored-source warning mask fields
    localparam int unsigned WS_CLIP_BIT      = 6;
    localparam int unsigned WS_CLK_BIT       = 5;
    localparam int unsigned WS_SHUTDOWN_BIT  = 4;
    localparam int unsigned WS_POWER_BIT     = 3;
    localparam int unsigned WS_OTWARN_BIT    = 2;
    localparam int unsigned WS_FOLDBACK_BIT  = 1;
    localparam int unsigned WS_CURCAP_BIT    = 0;

    // live warning mask fields
    localparam int unsigned WL_CLK_BIT       = 5;
    localparam int unsigned WL_SHUTDOWN_BIT  = 4;
    localparam int unsigned WL_POWER_BIT     = 3;
    localparam int unsigned WL_OTWARN_BIT    = 2;
    localparam int unsigned WL_FOLDBACK_BIT  = 1;
    localparam int unsigned WL_DIAG_BIT      = 0;

    // status register fields
    localparam int unsigned ST_FAULT_BIT     = 1;
    localparam int unsigned ST_WARN_BIT      = 0;

    // fault pin selection codes
    localparam int unsigned PIN_SEL_W        = 4;
    localparam logic [3:0] PIN_SEL_FAULT    = 4'h0;
    localparam logic [3:0] PIN_SEL_WARN     = 4'h1;

    // widths of the supply source groups
    localparam int unsigned PWR_LIVE_W       = 5;
    localparam int unsigned PWR_STORED_W     = 6;

endpackage

// File: design/fws_any_term.sv
// Purpose: one gated source term, any set bit of a group when enabled
// Assumes: sources already on the core clock
// Notes:   purely combinational, registered by the caller

`timescale 1ns/1ps
`default_nettype none

module fws_any_term #(
    parameter int unsigned W = 4
) (
    input  wire logic [W-1:0] src,  // source bits of the group
    input  wire logic         en,   // enable bit from a mask register
    output logic              hit   // group contributes
);

    initial begin
        if (W < 1) begin
            $error("fws_any_term: W must be at least 1");
        end
    end

    // a clear enable silences the whole group
    assign hit = en & (|src);

endmodule

`default_nettype wire

// File: design/fws_signal_mask.sv
// Purpose: masks diagnostic sources into the fault and warning signals
// Assumes: all source bits come from logic on core_clk
// Notes:   aggregated signals are registered, one cycle behind sources
//
// Function
// RQ1: fault follows warning when bit 6 set
// RQ2: live clock error drives fault via bit 5
// RQ3: live shutdown bits drive fault via bit 4
// RQ4: live supply faults drive fault via bit 3
// RQ5: unfinished diagnostics drive fault via bit 0
// RQ6: latched clip events drive warning via bit 6
// RQ7: latched clock error drives warning via bit 5
// RQ8: latched shutdown bits drive warning via bit 4
// RQ9: latched supply faults drive warning via bit 3
// RQ10: bit 2 resets set; latched overtemp warns
// RQ11: latched foldback drives warning via bit 1
// RQ12: latched current cap drives warning via bit 0
// RQ13: live clock error warns via live bit 5
// RQ14: live shutdown bits warn via live bit 4
// RQ15: live supply faults warn via live bit 3
// RQ16: overtemp warning warns via live bit 2
// RQ17: live foldback warns via live bit 1
// RQ18: unfinished diagnostics warn via live bit 0
// RQ19: pin code 0000 pulls low on fault
// RQ20: pin code 0001 pulls low on warning
// RQ21: signals are OR of enabled terms only
// RQ22: changes reach outputs within one cycle
//
// Decided for this implementation: the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none

module fws_signal_mask #(
    parameter int unsigned NUM_CH = fws_pkg::NUM_CH
) (
    input  wire logic              core_clk,           // core clock
    input  wire logic              reset_n,            // async reset
    input  wire logic [7:0]        regAddr,            // register offset
    input  wire logic [7:0]        regWrData,          // write data
    input  wire logic              regWrEn,            // write strobe
    input  wire logic              regRdEn,            // read strobe
    output logic      [7:0]        regRdData,          // read data
    input  wire logic              invalidClock,       // live clock error
    input  wire logic [NUM_CH-1:0] chOvertempShutdownStatus, // live
    input  wire logic              overtempShutdownStatus,   // live global
    input  wire logic [4:0]        supplyFaultLive,    // live supply
    input  wire logic [NUM_CH-1:0] chOvertempWarningStatus,  // live
    input  wire logic              overtempWarningStatus,    // live global
    input  wire logic              thermalFoldbackWarning,   // live
    input  wire logic [NUM_CH-1:0] loadDiagDoneReport, // diag done
    input  wire logic [NUM_CH-1:0] chClipLatched,      // latched clip
    input  wire logic              invalidClockLatched, // latched
    input  wire logic [NUM_CH-1:0] chShutdownLatched,  // latched
    input  wire logic              shutdownLatched,    // latched global
    input  wire logic [5:0]        supplyFaultLatched, // latched supply
    input  wire logic [NUM_CH-1:0] chOtWarnLatched,    // latched
    input  wire logic              otWarnLatched,      // latched global
    input  wire logic              foldbackLatched,    // latched
    input  wire logic [NUM_CH-1:0] chCurrentCapLatched, // latched
    output logic                   faultSignal,        // aggregated fault
    output logic                   warningSignal,      // aggregated warn
    output logic                   faultOutN,          // pin drive level
    output logic                   faultOutNOe         // pin pull enable
);

    initial begin
        if (NUM_CH < 1 || NUM_CH > 8) begin
            $error("fws_signal_mask: NUM_CH must be 1 to 8");
        end
    end

    typedef struct packed {
        logic [7:0] faultLiveMask;
        logic [7:0] warnStoredMask;
        logic [7:0] warnLiveMask;
        logic [7:0] pinConf;
        logic [7:0] rdData;
        logic       faultSig;
        logic       warnSig;
        logic       pinOe;
    } fws_state_t;

    fws_state_t st_r;
    fws_state_t st_nxt;

    // source groups, channel and global bits gathered together
    logic [NUM_CH:0] liveShutdownAll;
    logic [NUM_CH:0] latchedShutdownAll;
    logic [NUM_CH:0] liveOtWarnAll;
    logic [NUM_CH:0] latchedOtWarnAll;
    logic [NUM_CH-1:0] diagUnfinished;

    assign liveShutdownAll    = {overtempShutdownStatus,
                                 chOvertempShutdownStatus};
    assign latchedShutdownAll = {shutdownLatched, chShutdownLatched};
    assign liveOtWarnAll      = {overtempWarningStatus,
                                 chOvertempWarningStatus};
    assign latchedOtWarnAll   = {otWarnLatched, chOtWarnLatched};
    // a clear done bit means that channel has not finished
    assign diagUnfinished     = ~loadDiagDoneReport;

    logic [4:0]  faultHit;
    logic [12:0] warnHit;

    // live fault terms
    fws_any_term #(.W(1)) uFaultClk (
        .src (invalidClock),
        .en  (st_r.faultLiveMask[fws_pkg::FL_CLK_BIT]),
        .hit (faultHit[0])
    ); // see RQ2
    fws_any_term #(.W(NUM_CH + 1)) uFaultShut (
        .src (liveShutdownAll),
        .en  (st_r.faultLiveMask[fws_pkg::FL_SHUTDOWN_BIT]),
        .hit (faultHit[1])
    ); // see RQ3
    fws_any_term #(.W(fws_pkg::PWR_LIVE_W)) uFaultPwr (
        .src (supplyFaultLive),
        .en  (st_r.faultLiveMask[fws_pkg::FL_POWER_BIT]),
        .hit (faultHit[2])
    ); // see RQ4
    fws_any_term #(.W(NUM_CH)) uFaultDiag (
        .src (diagUnfinished),
        .en  (st_r.faultLiveMask[fws_pkg::FL_DIAG_BIT]),
        .hit (faultHit[3])
    ); // see RQ5

    // stored-source warning terms
    fws_any_term #(.W(NUM_CH)) uWarnClip (
        .src (chClipLatched),
        .en  (st_r.warnStoredMask[fws_pkg::WS_CLIP_BIT]),
        .hit (warnHit[0])
    ); // see RQ6
    fws_any_term #(.W(1)) uWarnClkS (
        .src (invalidClockLatched),
        .en  (st_r.warnStoredMask[fws_pkg::WS_CLK_BIT]),
        .hit (warnHit[1])
    ); // see RQ7
    fws_any_term #(.W(NUM_CH + 1)) uWarnShutS (
        .src (latchedShutdownAll),
        .en  (st_r.warnStoredMask[fws_pkg::WS_SHUTDOWN_BIT]),
        .hit (warnHit[2])
    ); // see RQ8
    fws_any_term #(.W(fws_pkg::PWR_STORED_W)) uWarnPwrS (
        .src (supplyFaultLatched),
        .en  (st_r.warnStoredMask[fws_pkg::WS_POWER_BIT]),
        .hit (warnHit[3])
    ); // see RQ9
    fws_any_term #(.W(NUM_CH + 1)) uWarnOtS (
        .src (latchedOtWarnAll),
        .en  (st_r.warnStoredMask[fws_pkg::WS_OTWARN_BIT]),
        .hit (warnHit[4])
    ); // see RQ10
    fws_any_term #(.W(1)) uWarnFbS (
        .src (foldbackLatched),
        .en  (st_r.warnStoredMask[fws_pkg::WS_FOLDBACK_BIT]),
        .hit (warnHit[5])
    ); // see RQ11
    fws_any_term #(.W(NUM_CH)) uWarnCapS (
        .src (chCurrentCapLatched),
        .en  (st_r.warnStoredMask[fws_pkg::WS_CURCAP_BIT]),
        .hit (warnHit[6])
    ); // see RQ12

    // live warning terms
    fws_any_term #(.W(1)) uWarnClkL (
        .src (invalidClock),
        .en  (st_r.warnLiveMask[fws_pkg::WL_CLK_BIT]),
        .hit (warnHit[7])
    ); // see RQ13
    fws_any_term #(.W(NUM_CH + 1)) uWarnShutL (
        .src (liveShutdownAll),
        .en  (st_r.warnLiveMask[fws_pkg::WL_SHUTDOWN_BIT]),
        .hit (warnHit[8])
    ); // see RQ14
    fws_any_term #(.W(fws_pkg::PWR_LIVE_W)) uWarnPwrL (
        .src (supplyFaultLive),
        .en  (st_r.warnLiveMask[fws_pkg::WL_POWER_BIT]),
        .hit (warnHit[9])
    ); // see RQ15
    // live bits chosen: the field is the live counterpart of bit 2
    fws_any_term #(.W(NUM_CH + 1)) uWarnOtL (
        .src (liveOtWarnAll),
        .en  (st_r.warnLiveMask[fws_pkg::WL_OTWARN_BIT]),
        .hit (warnHit[10])
    ); // see RQ16
    fws_any_term #(.W(1)) uWarnFbL (
        .src (thermalFoldbackWarning),
        .en  (st_r.warnLiveMask[fws_pkg::WL_FOLDBACK_BIT]),
        .hit (warnHit[11])
    ); // see RQ17
    fws_any_term #(.W(NUM_CH)) uWarnDiagL (
        .src (diagUnfinished),
        .en  (st_r.warnLiveMask[fws_pkg::WL_DIAG_BIT]),
        .hit (warnHit[12])
    ); // see RQ18

    logic warnNow;
    logic faultNow;

    // or of enabled terms; reserved bits feed no term at all
    assign warnNow  = |warnHit[12:0];                      // see RQ21
    assign faultHit[4] = st_r.faultLiveMask[fws_pkg::FL_FROM_WARN_BIT]
                         & warnNow;                          // see RQ1
    assign faultNow = |faultHit;                            // see RQ21

    // next state: bus access plus the aggregated signals
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rdData = fws_pkg::RD_IDLE;
        if (regWrEn) begin
            case (regAddr)
                fws_pkg::FAULT_LIVE_OFS:  st_nxt.faultLiveMask  = regWrData;
                fws_pkg::WARN_STORED_OFS: st_nxt.warnStoredMask = regWrData;
                fws_pkg::WARN_LIVE_OFS:   st_nxt.warnLiveMask   = regWrData;
                fws_pkg::FAULT_PIN_OFS:   st_nxt.pinConf        = regWrData;
                default: begin
                end
            endcase
        end
        if (regRdEn) begin
            case (regAddr)
                fws_pkg::FAULT_LIVE_OFS:  st_nxt.rdData = st_r.faultLiveMask;
                fws_pkg::WARN_STORED_OFS: st_nxt.rdData = st_r.warnStoredMask;
                fws_pkg::WARN_LIVE_OFS:   st_nxt.rdData = st_r.warnLiveMask;
                fws_pkg::FAULT_PIN_OFS:   st_nxt.rdData = st_r.pinConf;
                fws_pkg::SIG_STATUS_OFS: begin
                    st_nxt.rdData[fws_pkg::ST_FAULT_BIT] = st_r.faultSig;
                    st_nxt.rdData[fws_pkg::ST_WARN_BIT]  = st_r.warnSig;
                end
                default: begin
                end
            endcase
        end
        // no access needed for a source change to show
        st_nxt.faultSig = faultNow;                         // see RQ22
        st_nxt.warnSig  = warnNow;                          // see RQ22
        // open-drain pin: enable pulls low, other codes release it
        case (st_r.pinConf[fws_pkg::PIN_SEL_W-1:0])
            fws_pkg::PIN_SEL_FAULT: st_nxt.pinOe = faultNow; // see RQ19
            fws_pkg::PIN_SEL_WARN:  st_nxt.pinOe = warnNow;  // see RQ20
            default:                st_nxt.pinOe = 1'b0;
        endcase
    end

    // single state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.faultLiveMask  <= fws_pkg::FAULT_LIVE_RST;
            st_r.warnStoredMask <= fws_pkg::WARN_STORED_RST; // see RQ10
            st_r.warnLiveMask   <= fws_pkg::WARN_LIVE_RST;
            st_r.pinConf        <= fws_pkg::FAULT_PIN_RST;
            st_r.rdData         <= fws_pkg::RD_IDLE;
            st_r.faultSig       <= 1'b0;
            st_r.warnSig        <= 1'b0;
            st_r.pinOe          <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops, faultOutN tied low; pin only ever drives low
    assign regRdData     = st_r.rdData;
    assign faultSignal   = st_r.faultSig;
    assign warningSignal = st_r.warnSig;
    assign faultOutN     = 1'b0;
    assign faultOutNOe   = st_r.pinOe;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    fault_from_warn_a: // see RQ1
    assert property (st_r.faultLiveMask[fws_pkg::FL_FROM_WARN_BIT]
                     && warnNow |=> faultSignal && warningSignal)
    else $error("fault did not follow warning");

    fault_live_clk_a: // see RQ2
    assert property (invalidClock
                     && st_r.faultLiveMask[fws_pkg::FL_CLK_BIT]
                     |=> faultSignal)
    else $error("clock error did not raise fault");

    fault_live_pwr_a: // see RQ4
    assert property (|supplyFaultLive
                     && st_r.faultLiveMask[fws_pkg::FL_POWER_BIT]
                     |=> faultSignal)
    else $error("supply fault did not raise fault");

    fault_diag_a: // see RQ5
    assert property (!(&loadDiagDoneReport)
                     && st_r.faultLiveMask[fws_pkg::FL_DIAG_BIT]
                     |=> faultSignal)
    else $error("unfinished diagnostics did not raise fault");

    warn_clip_a: // see RQ6
    assert property (|chClipLatched
                     && st_r.warnStoredMask[fws_pkg::WS_CLIP_BIT]
                     |=> warningSignal)
    else $error("latched clip did not raise warning");

    warn_otwarn_a: // see RQ10
    assert property ($rose(|latchedOtWarnAll)
                     && st_r.warnStoredMask == fws_pkg::WARN_STORED_RST
                     |=> warningSignal)
    else $error("latched overtemp warning ignored at reset mask");

    warn_masks_off_a: // see RQ21
    assert property (st_r.warnStoredMask == 8'h00
                     && st_r.warnLiveMask == 8'h00
                     && st_r.faultLiveMask == 8'h00
                     |=> !warningSignal && !faultSignal)
    else $error("signal active with every mask clear");

    warn_foldback_a: // see RQ17
    assert property (thermalFoldbackWarning
                     && st_r.warnLiveMask[fws_pkg::WL_FOLDBACK_BIT]
                     ##1 thermalFoldbackWarning
                     && st_r.warnLiveMask[fws_pkg::WL_FOLDBACK_BIT]
                     |=> warningSignal)
    else $error("foldback did not raise warning");

    pin_select_a: // see RQ19
    assert property (st_r.pinConf[3:0] == fws_pkg::PIN_SEL_FAULT
                     && $stable(st_r.pinConf)
                     |-> faultOutNOe == faultSignal)
    else $error("fault pin does not follow fault signal");

    pin_warn_a: // see RQ20
    assert property (st_r.pinConf[3:0] == fws_pkg::PIN_SEL_WARN
                     && $stable(st_r.pinConf)
                     |-> faultOutNOe == warningSignal)
    else $error("fault pin does not follow warning signal");

    reg_readback_a: // see RQ22
    assert property (regRdEn && !regWrEn
                     && regAddr == fws_pkg::WARN_LIVE_OFS
                     |=> regRdData == $past(st_r.warnLiveMask))
    else $error("live warning mask read back wrong");

    write_steers_a: // see RQ13
    assert property (regWrEn && regAddr == fws_pkg::WARN_LIVE_OFS
                     && regWrData[fws_pkg::WL_CLK_BIT]
                     ##1 invalidClock |=> warningSignal)
    else $error("written live mask did not steer warning");

endmodule

`default_nettype wire

// File: test/test_fault_warning_signal_masking.sv
// Purpose: self-checking bench for the fault and warning masking block
// Assumes: registered outputs follow sources and masks one cycle later
// Notes:   sparse random sources, random masks, directed register checks

`timescale 1ns/1ps
`default_nettype none

module test_fault_warning_signal_masking;

    localparam int LIMIT = 12000;   // run is about 4400 cycles

    logic        core_clk;
    logic        reset_n;
    logic [7:0]  regAddr, regWrData, regRdData;
    logic        regWrEn, regRdEn;
    logic        invalidClock, overtempShutdownStatus, overtempWarningStatus;
    logic        thermalFoldbackWarning, invalidClockLatched;
    logic        shutdownLatched, otWarnLatched, foldbackLatched;
    logic [3:0]  chOvertempShutdownStatus, chOvertempWarningStatus;
    logic [3:0]  loadDiagDoneReport, chClipLatched, chShutdownLatched;
    logic [3:0]  chOtWarnLatched, chCurrentCapLatched;
    logic [4:0]  supplyFaultLive;
    logic [5:0]  supplyFaultLatched;
    logic        faultSignal, warningSignal, faultOutN, faultOutNOe;
    logic [7:0]  flMask, wsMask, wlMask, pinSel;   // bench copies of masks
    logic        expF, expW, expP, valid;
    integer      seed = 32'h8EAC2503;
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;

    fws_signal_mask #(.NUM_CH(4)) DUT (
        .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .invalidClock(invalidClock),
        .chOvertempShutdownStatus(chOvertempShutdownStatus),
        .overtempShutdownStatus(overtempShutdownStatus),
        .supplyFaultLive(supplyFaultLive),
        .chOvertempWarningStatus(chOvertempWarningStatus),
        .overtempWarningStatus(overtempWarningStatus),
        .thermalFoldbackWarning(thermalFoldbackWarning),
        .loadDiagDoneReport(loadDiagDoneReport),
        .chClipLatched(chClipLatched),
        .invalidClockLatched(invalidClockLatched),
        .chShutdownLatched(chShutdownLatched),
        .shutdownLatched(shutdownLatched),
        .supplyFaultLatched(supplyFaultLatched),
        .chOtWarnLatched(chOtWarnLatched), .otWarnLatched(otWarnLatched),
        .foldbackLatched(foldbackLatched),
        .chCurrentCapLatched(chCurrentCapLatched),
        .faultSignal(faultSignal), .warningSignal(warningSignal),
        .faultOutN(faultOutN), .faultOutNOe(faultOutNOe));

    // 250 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // warning term of every enabled source, live and latched
    function automatic logic calcWarn();
        calcWarn = (wsMask[fws_pkg::WS_CLIP_BIT] & |chClipLatched)
            | (wsMask[fws_pkg::WS_CLK_BIT] & invalidClockLatched)
            | (wsMask[fws_pkg::WS_SHUTDOWN_BIT]
               & (|chShutdownLatched | shutdownLatched))
            | (wsMask[fws_pkg::WS_POWER_BIT] & |supplyFaultLatched)
            | (wsMask[fws_pkg::WS_OTWARN_BIT]
               & (|chOtWarnLatched | otWarnLatched))
            | (wsMask[fws_pkg::WS_FOLDBACK_BIT] & foldbackLatched)
            | (wsMask[fws_pkg::WS_CURCAP_BIT] & |chCurrentCapLatched)
            | (wlMask[fws_pkg::WL_CLK_BIT] & invalidClock)
            | (wlMask[fws_pkg::WL_SHUTDOWN_BIT]
               & (|chOvertempShutdownStatus | overtempShutdownStatus))
            | (wlMask[fws_pkg::WL_POWER_BIT] & |supplyFaultLive)
            | (wlMask[fws_pkg::WL_OTWARN_BIT]
               & (|chOvertempWarningStatus | overtempWarningStatus))
            | (wlMask[fws_pkg::WL_FOLDBACK_BIT] & thermalFoldbackWarning)
            | (wlMask[fws_pkg::WL_DIAG_BIT] & ~&loadDiagDoneReport);
    endfunction

    function automatic logic calcFault(input logic w);
        calcFault = (flMask[fws_pkg::FL_FROM_WARN_BIT] & w)
            | (flMask[fws_pkg::FL_CLK_BIT] & invalidClock)
            | (flMask[fws_pkg::FL_SHUTDOWN_BIT]
               & (|chOvertempShutdownStatus | overtempShutdownStatus))
            | (flMask[fws_pkg::FL_POWER_BIT] & |supplyFaultLive)
            | (flMask[fws_pkg::FL_DIAG_BIT] & ~&loadDiagDoneReport);
    endfunction

    // outputs checked at each edge against what the prior edge saw;
    // pre-edge values are read here, so driver updates cannot race
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flMask = fws_pkg::FAULT_LIVE_RST;
            wsMask = fws_pkg::WARN_STORED_RST;
            wlMask = fws_pkg::WARN_LIVE_RST;
            pinSel = fws_pkg::FAULT_PIN_RST;
            valid  = 1'b0;
        end else begin
            if (valid) begin
                check("faultSignal", {7'h0, expF}, {7'h0, faultSignal});
                check("warningSignal", {7'h0, expW}, {7'h0, warningSignal});
                check("faultOutNOe", {7'h0, expP}, {7'h0, faultOutNOe});
                check("faultOutN", 8'h00, {7'h0, faultOutN});
            end
            expW  = calcWarn();
            expF  = calcFault(expW);
            // pin follows the code held before this edge's write lands
            expP  = (pinSel[3:0] == fws_pkg::PIN_SEL_FAULT) ? expF
                  : (pinSel[3:0] == fws_pkg::PIN_SEL_WARN) ? expW : 1'b0;
            valid = 1'b1;
            if (regWrEn) begin
                case (regAddr)
                    fws_pkg::FAULT_LIVE_OFS:  flMask = regWrData;
                    fws_pkg::WARN_STORED_OFS: wsMask = regWrData;
                    fws_pkg::WARN_LIVE_OFS:   wlMask = regWrData;
                    fws_pkg::FAULT_PIN_OFS:   pinSel = regWrData;
                    default: ;
                endcase
            end
        end
    end

    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            summarize();
        end
    end

    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge core_clk);
        regWrEn   <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic regRead(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        check("regRdData", exp, regRdData);
    endtask

    // sparse sources so single terms can be told apart
    task automatic randSources();
        logic [63:0] r;
        r = {$random(seed), $random(seed)} & {$random(seed), $random(seed)}
            & {$random(seed), $random(seed)};
        if (($random(seed) & 3) == 0)
            r = 64'h0;
        @(posedge core_clk);
        {chCurrentCapLatched, foldbackLatched, otWarnLatched,
         chOtWarnLatched, supplyFaultLatched, shutdownLatched,
         chShutdownLatched, invalidClockLatched, chClipLatched} <= r[46:21];
        loadDiagDoneReport <= ~r[20:17];
        {thermalFoldbackWarning, overtempWarningStatus,
         chOvertempWarningStatus, supplyFaultLive, overtempShutdownStatus,
         chOvertempShutdownStatus, invalidClock} <= r[16:0];
    endtask

    logic [7:0] ofs [6] = '{8'h1E, 8'h1F, 8'h20, 8'h22, 8'h2F, 8'h05};
    logic [7:0] rst [6] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] a, d;

    initial begin
        {regAddr, regWrData, regWrEn, regRdEn} = '0;
        {invalidClock, chOvertempShutdownStatus, overtempShutdownStatus,
         supplyFaultLive, chOvertempWarningStatus, overtempWarningStatus,
         thermalFoldbackWarning, chClipLatched, invalidClockLatched,
         chShutdownLatched, shutdownLatched, supplyFaultLatched,
         chOtWarnLatched, otWarnLatched, foldbackLatched,
         chCurrentCapLatched} = '0;
        loadDiagDoneReport = 4'hF;
        reset_n = 1'b0;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        // reset values, unmapped and status offsets
        foreach (ofs[i])
            regRead(ofs[i], rst[i]);
        // reserved bits are stored; read straight after write
        for (int i = 0; i < 4; i++) begin
            regWrite(ofs[i], 8'hFF);
            regRead(ofs[i], 8'hFF);
        end
        // every mask clear: busy sources must reach neither signal
        for (int i = 0; i < 3; i++)
            regWrite(ofs[i], 8'h00);
        repeat (20) randSources();
        repeat (3000) begin
            if (($random(seed) & 7) == 0) begin
                a = ofs[{$random(seed)} % 4];
                d = ($random(seed) & 1) ? (8'h01 << ($random(seed) & 7))
                                        : $random(seed);
                if (a == fws_pkg::FAULT_PIN_OFS)
                    d = (d & 8'hF0) | 8'({$random(seed)} % 3);
                regWrite(a, d);
                regRead(a, d);
            end else begin
                randSources();
            end
        end
        // second reset in mid-run restores the masks
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        regRead(8'h1F, 8'h04);
        regRead(8'h20, 8'h00);
        repeat (200) randSources();
        summarize();
    end

endmodule

`default_nettype wire
